// >>> design/cfrb_pkg.sv
package cfrb_pkg;
  // register byte offsets
  localparam logic [6:0] MAKER_RESERVED_BYTE_OFS = 7'h00;
  localparam logic [6:0] UPPER_GROUP_PHASE_OFS   = 7'h01;
  localparam logic [6:0] UPPER_GROUP_DIVIDER_OFS = 7'h02;
  localparam logic [6:0] LOWER_GROUP_PHASE_OFS   = 7'h03;
  localparam logic [6:0] LOWER_GROUP_DIVIDER_OFS = 7'h04;
  localparam logic [6:0] CHIP_UPPER_ENABLES_OFS  = 7'h05;
  localparam logic [6:0] LOWER_OUTPUT_ENABLES_OFS = 7'h06;

  // power-up values
  localparam logic [7:0] UPPER_GROUP_PHASE_RST    = 8'h20;
  localparam logic [7:0] UPPER_GROUP_DIVIDER_RST  = 8'h30;
  localparam logic [7:0] LOWER_GROUP_PHASE_RST    = 8'h00;
  localparam logic [7:0] LOWER_GROUP_DIVIDER_RST  = 8'h30;
  localparam logic [7:0] CHIP_UPPER_ENABLES_RST   = 8'hff;
  localparam logic [7:0] LOWER_OUTPUT_ENABLES_RST = 8'hf0;
  // arbitrary neutral value
  localparam logic [7:0] MAKER_RESERVED_BITS_VAL  = 8'h00;

  // field positions
  localparam int PHASE_SELECT_ENABLE_BIT = 5;
  localparam int PHASE_CODE_MSB          = 4;
  localparam int DIVIDER_ENABLE_BIT      = 5;
  localparam int RATIO_CODE_MSB          = 3;
  localparam int CHIP_ENABLE_BIT         = 7;
  localparam int CHIP_RO_RESERVED_BIT    = 6;
  localparam int UPPER_DRV_MSB           = 5;
  localparam int LOWER_DRV_LSB           = 4;
  localparam int NUM_OUTPUTS             = 10;
  localparam int GROUP_SIZE              = 5;

  // divide ratio select codes
  localparam logic [3:0] RATIO_CODE_1  = 4'h0;
  localparam logic [3:0] RATIO_CODE_2  = 4'h1;
  localparam logic [3:0] RATIO_CODE_4  = 4'h2;
  localparam logic [3:0] RATIO_CODE_5  = 4'h3;
  localparam logic [3:0] RATIO_CODE_8  = 4'h4;
  localparam logic [3:0] RATIO_CODE_10 = 4'h5;
  localparam logic [3:0] RATIO_CODE_16 = 4'h6;
  localparam logic [3:0] RATIO_CODE_20 = 4'h7;
  localparam logic [3:0] RATIO_CODE_32 = 4'h8;
  localparam logic [3:0] RATIO_CODE_40 = 4'h9;
  localparam logic [3:0] RATIO_CODE_80 = 4'ha;
endpackage : cfrb_pkg

// >>> design/cfrb_ratio_dec.sv
`timescale 1ns/1ps
`default_nettype none
module cfrb_ratio_dec
  import cfrb_pkg::*;
(
  cfrb_ratio_if.dec rif  // code in, ratio out
);
  // select code to ratio, undefined codes fall back to 1
  always_comb begin
    rif.supported = 1'b1;
    case (rif.code)
      RATIO_CODE_1:  rif.ratio = 7'h01;
      RATIO_CODE_2:  rif.ratio = 7'h02;
      RATIO_CODE_4:  rif.ratio = 7'h04;
      RATIO_CODE_5:  rif.ratio = 7'h05;
      RATIO_CODE_8:  rif.ratio = 7'h08;
      RATIO_CODE_10: rif.ratio = 7'h0a;
      RATIO_CODE_16: rif.ratio = 7'h10;
      RATIO_CODE_20: rif.ratio = 7'h14;
      RATIO_CODE_32: rif.ratio = 7'h20;
      RATIO_CODE_40: rif.ratio = 7'h28;
      RATIO_CODE_80: rif.ratio = 7'h50;
      default: begin
        rif.ratio     = 7'h01;
        rif.supported = 1'b0;
      end
    endcase
  end
endmodule : cfrb_ratio_dec
`default_nettype wire

// >>> design/cfrb_ratio_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cfrb_ratio_if;
  logic [3:0] code;      // select code from register
  logic [6:0] ratio;     // decoded divide ratio
  logic       supported; // code is a defined ratio
  modport bank (output code, input ratio, input supported);
  modport dec  (input code, output ratio, output supported);
endinterface : cfrb_ratio_if
`default_nettype wire

// >>> design/cfrb_regs.sv
`timescale 1ns/1ps
`default_nettype none
module cfrb_regs
  import cfrb_pkg::*;
(
  input  wire logic       REF_CLK_IN,              // 200 MHz clock
  input  wire logic       NRST_IN,                 // async reset, active low
  input  wire logic [6:0] REG_OFS_IN,              // byte offset from command code
  input  wire logic       REG_WR_IN,               // write strobe, one cycle
  input  wire logic [7:0] REG_WDATA_IN,            // write data
  input  wire logic       REG_RD_IN,               // read strobe, one cycle
  output logic      [7:0] REG_RDATA_OUT,           // read data
  output logic            REG_RVALID_OUT,          // read data valid pulse
  output logic            CHIP_ENABLE_OUT,         // chip active
  output logic            QUIESCENT_OUT,           // low-current mode
  output logic [9:0]      OUTPUT_DRIVER_ENABLE_OUT, // per-output drive enables
  output logic            PHASE_SELECT_ENABLE_OUT, // phase adjust on
  output logic [4:0]      UPPER_PHASE_OUT,         // upper group phase code
  output logic [4:0]      LOWER_PHASE_OUT,         // lower group phase code
  output logic [6:0]      UPPER_RATIO_OUT,         // upper group divide ratio
  output logic [6:0]      LOWER_RATIO_OUT,         // lower group divide ratio
  output logic [1:0]      RATIO_UNSUPPORTED_OUT,   // [1] upper, [0] lower
  output logic            DIVIDER_RESYNC_OUT       // divider reset pulse
);
  logic [7:0] upper_group_phase_q;
  logic [7:0] upper_group_divider_q;
  logic [7:0] lower_group_phase_q;
  logic [7:0] lower_group_divider_q;
  logic [7:0] chip_and_upper_output_enables_q;
  logic [7:0] lower_output_enables_q;
  logic [7:0] rdata_d;
  logic [9:0] drv_en_d;
  logic [9:0] output_driver_enable;
  logic       chip_en;
  logic       upper_divider_enable;
  logic       lower_divider_enable;

  // index 1 is upper group, index 0 lower group
  cfrb_ratio_if rif [2] ();

  assign rif[1].code = upper_group_divider_q[RATIO_CODE_MSB:0];
  assign rif[0].code = lower_group_divider_q[RATIO_CODE_MSB:0];

  // ratio decoders, one per group
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_dec
      cfrb_ratio_dec u_dec (
        .rif (rif[g])
      );
    end
  endgenerate

  // the serial engine strips bit 7 of the command; offset arrives here
  // upper group phase byte
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      upper_group_phase_q <= UPPER_GROUP_PHASE_RST;
    end else if (REG_WR_IN && REG_OFS_IN == UPPER_GROUP_PHASE_OFS) begin
      upper_group_phase_q <= REG_WDATA_IN;
    end
  end

  // upper group divider byte
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      upper_group_divider_q <= UPPER_GROUP_DIVIDER_RST;
    end else if (REG_WR_IN && REG_OFS_IN == UPPER_GROUP_DIVIDER_OFS) begin
      upper_group_divider_q <= REG_WDATA_IN;
    end
  end

  // lower group phase byte
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      lower_group_phase_q <= LOWER_GROUP_PHASE_RST;
    end else if (REG_WR_IN && REG_OFS_IN == LOWER_GROUP_PHASE_OFS) begin
      lower_group_phase_q <= REG_WDATA_IN;
    end
  end

  // lower group divider byte
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      lower_group_divider_q <= LOWER_GROUP_DIVIDER_RST;
    end else if (REG_WR_IN && REG_OFS_IN == LOWER_GROUP_DIVIDER_OFS) begin
      lower_group_divider_q <= REG_WDATA_IN;
    end
  end

  // chip enable and upper output enables
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      chip_and_upper_output_enables_q <= CHIP_UPPER_ENABLES_RST;
    end else if (REG_WR_IN && REG_OFS_IN == CHIP_UPPER_ENABLES_OFS) begin
      chip_and_upper_output_enables_q <= REG_WDATA_IN;
      chip_and_upper_output_enables_q[CHIP_RO_RESERVED_BIT] <=
        CHIP_UPPER_ENABLES_RST[CHIP_RO_RESERVED_BIT];
    end
  end

  // lower output enables
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      lower_output_enables_q <= LOWER_OUTPUT_ENABLES_RST;
    end else if (REG_WR_IN && REG_OFS_IN == LOWER_OUTPUT_ENABLES_OFS) begin
      lower_output_enables_q <= REG_WDATA_IN;
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    case (REG_OFS_IN)
      MAKER_RESERVED_BYTE_OFS:  rdata_d = MAKER_RESERVED_BITS_VAL;
      UPPER_GROUP_PHASE_OFS:    rdata_d = upper_group_phase_q;
      UPPER_GROUP_DIVIDER_OFS:  rdata_d = upper_group_divider_q;
      LOWER_GROUP_PHASE_OFS:    rdata_d = lower_group_phase_q;
      LOWER_GROUP_DIVIDER_OFS:  rdata_d = lower_group_divider_q;
      CHIP_UPPER_ENABLES_OFS:   rdata_d = chip_and_upper_output_enables_q;
      LOWER_OUTPUT_ENABLES_OFS: rdata_d = lower_output_enables_q;
      default:                  rdata_d = 8'h00;
    endcase
  end

  // read answer one cycle after strobe
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      REG_RDATA_OUT  <= 8'h00;
      REG_RVALID_OUT <= 1'b0;
    end else begin
      REG_RVALID_OUT <= REG_RD_IN;
      if (REG_RD_IN) begin
        REG_RDATA_OUT <= rdata_d;
      end
    end
  end

  // field taps from the register bytes
  assign chip_en              = chip_and_upper_output_enables_q[CHIP_ENABLE_BIT];
  assign upper_divider_enable = upper_group_divider_q[DIVIDER_ENABLE_BIT];
  assign lower_divider_enable = lower_group_divider_q[DIVIDER_ENABLE_BIT];
  assign output_driver_enable = {chip_and_upper_output_enables_q[UPPER_DRV_MSB:0],
                                 lower_output_enables_q[7:LOWER_DRV_LSB]};

  // effective drive enable per output
  generate
    for (g = 0; g < NUM_OUTPUTS; g++) begin : g_drv
      if (g >= GROUP_SIZE) begin : g_up
        assign drv_en_d[g] = chip_en & upper_divider_enable & output_driver_enable[g];
      end else begin : g_lo
        assign drv_en_d[g] = chip_en & lower_divider_enable & output_driver_enable[g];
      end
    end
  endgenerate

  // registered control outputs
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      CHIP_ENABLE_OUT          <= 1'b1;
      QUIESCENT_OUT            <= 1'b0;
      OUTPUT_DRIVER_ENABLE_OUT <= 10'h3ff;
      PHASE_SELECT_ENABLE_OUT  <= 1'b1;
      UPPER_PHASE_OUT          <= 5'h00;
      LOWER_PHASE_OUT          <= 5'h00;
    end else begin
      CHIP_ENABLE_OUT          <= chip_en;
      QUIESCENT_OUT            <= ~chip_en;
      OUTPUT_DRIVER_ENABLE_OUT <= drv_en_d;
      PHASE_SELECT_ENABLE_OUT  <= upper_group_phase_q[PHASE_SELECT_ENABLE_BIT];
      UPPER_PHASE_OUT          <= upper_group_phase_q[PHASE_CODE_MSB:0];
      LOWER_PHASE_OUT          <= lower_group_phase_q[PHASE_CODE_MSB:0];
    end
  end

  // decoded ratios and unsupported flags
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      UPPER_RATIO_OUT       <= 7'h01;
      LOWER_RATIO_OUT       <= 7'h01;
      RATIO_UNSUPPORTED_OUT <= 2'h0;
    end else begin
      UPPER_RATIO_OUT       <= rif[1].ratio;
      LOWER_RATIO_OUT       <= rif[0].ratio;
      RATIO_UNSUPPORTED_OUT <= {~rif[1].supported, ~rif[0].supported};
    end
  end

  // divider resync pulse after each write
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      DIVIDER_RESYNC_OUT <= 1'b0;
    end else begin
      DIVIDER_RESYNC_OUT <= REG_WR_IN;
    end
  end
endmodule : cfrb_regs
`default_nettype wire

// >>> testbench/cfrb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module cfrb_host_model (
  input  wire logic       clk_in,    // bench clock
  input  wire logic [7:0] rdata_in,  // read data
  input  wire logic       rvalid_in, // read valid
  output var  logic [6:0] ofs_out,   // offset
  output var  logic       wr_out,    // write strobe
  output var  logic [7:0] wdata_out, // write data
  output var  logic       rd_out     // read strobe
);
  // idle values at time zero
  initial begin
    ofs_out = 7'h00;
    wr_out = 1'b0;
    wdata_out = 8'h00;
    rd_out = 1'b0;
  end
  // one byte access, released data inverted afterwards
  task automatic put(input logic [7:0] cmd, input logic w, input logic [7:0] d);
    @(negedge clk_in);
    ofs_out = cmd[6:0];
    wdata_out = d;
    wr_out = w;
    rd_out = !w;
    @(negedge clk_in);
    wr_out = 1'b0;
    rd_out = 1'b0;
    ofs_out = ~ofs_out;
    wdata_out = ~wdata_out;
  endtask : put
  // byte read, bounded wait on valid
  task automatic read(input logic [7:0] cmd, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    put(cmd, 1'b0, 8'h00);
    for (int i = 0; i < 4 && !ok; i++) begin
      if (rvalid_in === 1'b1) begin
        d = rdata_in;
        ok = 1'b1;
      end else @(negedge clk_in);
    end
  endtask : read
endmodule : cfrb_host_model
`default_nettype wire

// >>> testbench/cfrb_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
module cfrb_regs_props
  import cfrb_pkg::*;
(
  input wire logic       REF_CLK_IN,               // clock
  input wire logic       NRST_IN,                  // reset, active low
  input wire logic [6:0] REG_OFS_IN,               // offset
  input wire logic       REG_WR_IN,                // write strobe
  input wire logic [7:0] REG_WDATA_IN,             // write data
  input wire logic       REG_RD_IN,                // read strobe
  input wire logic [7:0] REG_RDATA_OUT,            // read data
  input wire logic       CHIP_ENABLE_OUT,          // chip on
  input wire logic       QUIESCENT_OUT,            // low current
  input wire logic [9:0] OUTPUT_DRIVER_ENABLE_OUT, // drivers
  input wire logic [6:0] UPPER_RATIO_OUT,          // upper ratio
  input wire logic [1:0] RATIO_UNSUPPORTED_OUT,    // bad code flags
  input wire logic       DIVIDER_RESYNC_OUT        // resync pulse
);
  // single clock domain
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!NRST_IN);
  // port relations
  a_resync_on_write: assert property (REG_WR_IN |=> DIVIDER_RESYNC_OUT)
    else $error("resync missing after write");
  a_resync_no_write: assert property (DIVIDER_RESYNC_OUT |-> $past(REG_WR_IN))
    else $error("resync without write");
  a_maker_byte_read: assert property (REG_RD_IN && REG_OFS_IN == MAKER_RESERVED_BYTE_OFS
    |=> REG_RDATA_OUT == MAKER_RESERVED_BITS_VAL)
    else $error("maker byte changed");
  a_ro_bit_read: assert property (REG_RD_IN && REG_OFS_IN == 7'h05 |=> REG_RDATA_OUT[6])
    else $error("read-only bit not one");
  a_unmapped_read_zero: assert property (REG_RD_IN && REG_OFS_IN > 7'h06
    |=> REG_RDATA_OUT == 8'h00)
    else $error("unmapped read not zero");
  a_quiescent_inverse: assert property (QUIESCENT_OUT != CHIP_ENABLE_OUT)
    else $error("quiescent not inverse of enable");
  a_chip_off_drv: assert property (!CHIP_ENABLE_OUT |-> OUTPUT_DRIVER_ENABLE_OUT == 10'h000)
    else $error("drivers on while chip off");
  a_ratio_legal: assert property (UPPER_RATIO_OUT inside {1, 2, 4, 5, 8, 10, 16,
    20, 32, 40, 80})
    else $error("illegal upper ratio");
  a_unsup_ratio_one: assert property (RATIO_UNSUPPORTED_OUT[1] |-> UPPER_RATIO_OUT == 7'h01)
    else $error("unsupported code ratio not one");
  a_ratio_one_write: assert property (REG_WR_IN && REG_OFS_IN == UPPER_GROUP_DIVIDER_OFS
    && REG_WDATA_IN[3:0] == RATIO_CODE_1 |-> ##2 UPPER_RATIO_OUT == 7'h01)
    else $error("ratio code zero not ratio one");
  // main scenarios reached
  c_write_seen: cover property (REG_WR_IN);
  c_quiescent: cover property (QUIESCENT_OUT);
  c_both_unsup: cover property (RATIO_UNSUPPORTED_OUT == 2'h3);
endmodule : cfrb_regs_props
bind cfrb_regs cfrb_regs_props u_props (.REF_CLK_IN(REF_CLK_IN), .NRST_IN(NRST_IN),
  .REG_OFS_IN(REG_OFS_IN), .REG_WR_IN(REG_WR_IN), .REG_WDATA_IN(REG_WDATA_IN),
  .REG_RD_IN(REG_RD_IN), .REG_RDATA_OUT(REG_RDATA_OUT), .CHIP_ENABLE_OUT(CHIP_ENABLE_OUT),
  .QUIESCENT_OUT(QUIESCENT_OUT), .OUTPUT_DRIVER_ENABLE_OUT(OUTPUT_DRIVER_ENABLE_OUT),
  .UPPER_RATIO_OUT(UPPER_RATIO_OUT), .RATIO_UNSUPPORTED_OUT(RATIO_UNSUPPORTED_OUT),
  .DIVIDER_RESYNC_OUT(DIVIDER_RESYNC_OUT));
`default_nettype wire

// >>> testbench/cfrb_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cfrb_regs_tb
  import cfrb_pkg::*;
;
  logic       clk, nrst, wr, rd, rv, ce, qs, pse, rs;
  logic [6:0] ofs, urat, lrat;
  logic [7:0] wd, rdat, d, e;
  logic [9:0] drv;
  logic [4:0] uph, lph;
  logic [1:0] uns;
  int         n_errors, cmp_count;
  logic [7:0] rst_v [7] = '{MAKER_RESERVED_BITS_VAL, 8'h20, 8'h30, 8'h00, 8'h30, 8'hff, 8'hf0};
  logic [6:0] rat [16] = '{7'h01, 7'h02, 7'h04, 7'h05, 7'h08, 7'h0a, 7'h10, 7'h14, 7'h20,
                           7'h28, 7'h50, 7'h01, 7'h01, 7'h01, 7'h01, 7'h01};
  cfrb_host_model m (.clk_in(clk), .rdata_in(rdat), .rvalid_in(rv), .ofs_out(ofs), .wr_out(wr),
    .wdata_out(wd), .rd_out(rd));
  cfrb_regs dut (.REF_CLK_IN(clk), .NRST_IN(nrst), .REG_OFS_IN(ofs), .REG_WR_IN(wr),
    .REG_WDATA_IN(wd), .REG_RD_IN(rd), .REG_RDATA_OUT(rdat), .REG_RVALID_OUT(rv),
    .CHIP_ENABLE_OUT(ce), .QUIESCENT_OUT(qs), .OUTPUT_DRIVER_ENABLE_OUT(drv),
    .PHASE_SELECT_ENABLE_OUT(pse), .UPPER_PHASE_OUT(uph), .LOWER_PHASE_OUT(lph),
    .UPPER_RATIO_OUT(urat), .LOWER_RATIO_OUT(lrat), .RATIO_UNSUPPORTED_OUT(uns),
    .DIVIDER_RESYNC_OUT(rs));
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // verdict and end of run
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  // compare seen against expected
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // read with timeout handling
  task automatic rdb(input logic [7:0] cmd, output logic [7:0] v);
    logic ok;
    m.read(cmd, v, ok);
    if (ok !== 1'b1) begin
      n_errors++;
      print_verdict;
    end
  endtask : rdb
  // reset pulse, then every byte and the control outputs back at power-up values
  task automatic rst_chk;
    nrst = 1'b0;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    for (int i = 0; i < 7; i++) begin
      rdb(8'h80 | 8'(i), d);
      chk("reset byte", d, rst_v[i]);
    end
    chk("reset outputs", {ce, qs, pse, drv}, {3'h5, 10'h3ff});
    chk("reset phases", {uph, lph}, 10'h000);
    $display("test reset values done");
  endtask : rst_chk
  // test sequence
  initial begin
    rst_chk;
    foreach (rst_v[p]) if (p < 2) begin
      e = p ? 8'hff : 8'h00;
      for (int i = 0; i < 8; i++) m.put(8'h80 | 8'(i), 1'b1, e);
      for (int i = 0; i < 8; i++) begin
        rdb(8'h80 | 8'(i), d);
        chk("readback", d, i == 0 ? MAKER_RESERVED_BITS_VAL : i > 6 ? 8'h00 :
            i == 5 ? e | 8'h40 : e);
      end
      chk("chip state", {ce, qs, drv}, {e[7], ~e[7], e[7] ? 10'h3ff : 10'h000});
      chk("unsupported", uns, {e[7], e[7]});
    end
    $display("test access kinds done");
    for (int c = 0; c < 16; c++) begin
      m.put(8'h82, 1'b1, 8'h30 | 8'(c));
      m.put(8'h84, 1'b1, 8'h30 | 8'(15 - c));
      @(negedge clk);
      chk("ratios", {urat, lrat}, {rat[c], rat[15 - c]});
      chk("ratio flags", uns, {c > 10, c < 5});
    end
    $display("test ratio codes done");
    m.put(8'h85, 1'b1, 8'ha5);
    m.put(8'h86, 1'b1, 8'h50);
    m.put(8'h81, 1'b1, 8'h15);
    m.put(8'h83, 1'b1, 8'h0b);
    chk("resync", rs, 1'b1);
    @(negedge clk);
    chk("drivers", drv, 10'h255);
    chk("phase", {pse, uph, lph}, {1'b0, 5'h15, 5'h0b});
    chk("resync end", rs, 1'b0);
    m.put(8'h82, 1'b1, 8'h10);
    @(negedge clk);
    chk("upper off", drv, 10'h015);
    m.put(8'h84, 1'b1, 8'h10);
    @(negedge clk);
    chk("lower off", drv, 10'h000);
    $display("test enables done");
    rst_chk;
    print_verdict;
  end
endmodule : cfrb_regs_tb
`default_nettype wire
